// ---- rtl/cepo_pkg.sv ----
// Constants and types of the CANopen error and drive profile objects
package cepo_pkg;
  localparam logic [15:0] IDX_ERR_REG = 16'h1001;
  localparam logic [15:0] IDX_LAST_CODE = 16'h603F;
  localparam logic [15:0] IDX_SUP_MODES = 16'h6502;
  localparam logic [15:0] IDX_MODE_OP = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISP = 16'h6061;
  localparam logic [31:0] SUP_MODES_VAL = 32'h0000_000A;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MODE_VL = 8'h02;
  localparam logic [7:0] MODE_TQ = 8'h04;
  localparam logic [3:0] PDO_TQ = 4'h5;
  localparam logic [3:0] PDO_VL = 4'h6;
  localparam logic PROF_EN_RST = 1'b0;
  localparam logic [15:0] CODE_CLEAR = 16'h0000;
  localparam int EB_GEN = 0;
  localparam int EB_CUR = 1;
  localparam int EB_VOLT = 2;
  localparam int EB_TEMP = 3;
  localparam int EB_MFR = 7;
  localparam logic signed [47:0] SECS_PER_MIN = 48'h0000_0000_003C;
  localparam logic [47:0] OL_RAMP_NUM = 48'h0000_0000_0258;
  localparam logic [47:0] OL_RAMP_SCALE = 48'h0000_0000_0064;
  localparam logic [47:0] CL_RAMP_SCALE = 48'h0000_000F_4240;
  localparam logic signed [15:0] S16_MAX = 16'sh7FFF;
  localparam logic signed [15:0] S16_MIN = 16'sh8000;
  localparam logic [31:0] U32_MAX = 32'hFFFF_FFFF;
  typedef enum logic {EM_FREE, EM_ERROR} cepo_emst_e;
endpackage

// ---- rtl/cepo_emcy_if.sv ----
// Hand-over of one emergency message to the transmit stage
`timescale 1ns/1ps
`default_nettype none
interface cepo_emcy_if;
  logic send;
  logic busy;
  logic [63:0] msg;
  modport src (output send, output msg, input busy);
  modport snk (input send, input msg, output busy);
endinterface
`default_nettype wire

// ---- rtl/cepo_emcy_tx.sv ----
// Emergency message holding stage with valid/ready towards the network
`timescale 1ns/1ps
`default_nettype none
module cepo_emcy_tx (
  input wire logic clk,
  input wire logic rst,
  cepo_emcy_if.snk req,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [63:0] tx_data
);
  import cepo_pkg::*;
  logic valid_r;
  logic [63:0] data_r;

  // --------------------------------------------------------------
  // One message in flight
  // --------------------------------------------------------------
  // Only one message is held, so each message accepted from req is sent exactly once
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_r <= 1'b0;
    end else if (req.send && !valid_r) begin
      valid_r <= 1'b1;
    end else if (tx_ready) begin
      valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_r <= 64'h0000_0000_0000_0000;
    end else if (req.send && !valid_r) begin
      data_r <= req.msg;
    end
  end

  assign req.busy = valid_r;
  assign tx_valid = valid_r;
  assign tx_data = data_r;

  valid_hold_a: assert property (@(posedge clk) disable iff (rst)
    valid_r && !tx_ready |=> valid_r && $stable(data_r))
    else $error("Emergency message dropped or changed before taken");
endmodule
`default_nettype wire

// ---- rtl/cepo_objects.sv ----
// Error register, emergency generation and drive profile objects
`timescale 1ns/1ps
`default_nettype none
module cepo_objects (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic DRV_TRIP,
  input wire logic DRV_OVERCURRENT,
  input wire logic DRV_UNDERVOLTAGE_TRIP,
  input wire logic DRV_OVERTEMP,
  input wire logic DRV_WARNING_PARAM,
  input wire logic [15:0] DRV_FAULT_CODE,
  input wire logic [7:0] DRV_TRIP_CODE,
  input wire logic [7:0] MOD_ERR_CODE,
  input wire logic APP_ASSOC_WR,
  input wire logic [31:0] APP_ASSOC,
  input wire logic EMCY_READY,
  output logic EMCY_VALID,
  output logic [63:0] EMCY_DATA,
  output logic [7:0] FAULT_CLASS_FLAGS,
  output logic [15:0] LAST_FAULT_CODE,
  input wire logic OD_REQ,
  input wire logic OD_WR,
  input wire logic [15:0] OD_INDEX,
  input wire logic [31:0] OD_WDATA,
  output logic OD_ACK,
  output logic OD_ERR,
  output logic [31:0] OD_RDATA,
  input wire logic PROFILE_ENABLE_WR,
  input wire logic PROFILE_ENABLE_PARAM,
  input wire logic RPDO_VALID,
  input wire logic [3:0] RPDO_NUM,
  input wire logic [31:0] RPDO_DATA,
  input wire logic [15:0] STATUSWORD,
  input wire logic [15:0] TORQUE_ACTUAL,
  input wire logic [15:0] DRIVE_SPEED_FB,
  output logic [15:0] CONTROLWORD,
  output logic [15:0] TARGET_TORQUE,
  output logic [15:0] VL_TARGET_VELOCITY,
  output logic [31:0] TPDO5_DATA,
  output logic [31:0] TPDO6_DATA,
  input wire logic OPEN_LOOP,
  input wire logic [7:0] MOTOR_POLE_PAIRS,
  input wire logic [15:0] DELTA_TIME,
  input wire logic [31:0] DELTA_SPEED,
  output logic [15:0] DRIVE_SPEED_REF,
  output logic [31:0] DRIVE_RAMP
);
  import cepo_pkg::*;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  // --------------------------------------------------------------
  // Error register
  // --------------------------------------------------------------
  logic [7:0] err_reg_r;
  logic [7:0] err_reg_nxt;

  always_comb begin
    err_reg_nxt = 8'h00;
    err_reg_nxt[EB_CUR] = DRV_OVERCURRENT;
    err_reg_nxt[EB_VOLT] = DRV_UNDERVOLTAGE_TRIP;
    err_reg_nxt[EB_TEMP] = DRV_OVERTEMP;
    err_reg_nxt[EB_MFR] = DRV_WARNING_PARAM;
    // A trip outside the listed classes still counts as generic
    err_reg_nxt[EB_GEN] = (|err_reg_nxt) | DRV_TRIP;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      err_reg_r <= 8'h00;
    end else begin
      err_reg_r <= err_reg_nxt;
    end
  end

  assign FAULT_CLASS_FLAGS = err_reg_r;

  // --------------------------------------------------------------
  // Drive and application error tracking
  // --------------------------------------------------------------
  logic drv_prev_r;
  logic [15:0] last_code_r;
  logic app_act_r;
  logic app_prev_r;
  logic app_new_r;
  logic [15:0] app_code_r;
  logic [7:0] app_b2_r;
  logic [7:0] app_b3_r;
  logic app_new;
  logic app_zero;
  logic drv_new;
  logic part_clear;
  logic all_clear;
  logic any_act;

  assign app_zero = APP_ASSOC[15:0] == CODE_CLEAR;
  assign app_new = APP_ASSOC_WR && !app_zero &&
    (!app_act_r || APP_ASSOC[15:0] != app_code_r);
  assign drv_new = DRV_TRIP &&
    (!drv_prev_r || DRV_FAULT_CODE != last_code_r);
  assign any_act = DRV_TRIP || app_act_r;
  // One of two sources cleared while the other remains
  assign part_clear = any_act &&
    ((drv_prev_r && !DRV_TRIP) || (app_prev_r && !app_act_r));
  assign all_clear = (drv_prev_r || app_prev_r) && !any_act;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      drv_prev_r <= 1'b0;
      app_prev_r <= 1'b0;
    end else begin
      drv_prev_r <= DRV_TRIP;
      app_prev_r <= app_act_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      last_code_r <= CODE_CLEAR;
    end else if (drv_new) begin
      last_code_r <= DRV_FAULT_CODE;
    end
  end

  assign LAST_FAULT_CODE = last_code_r;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      app_act_r <= 1'b0;
      app_new_r <= 1'b0;
      app_code_r <= CODE_CLEAR;
      app_b2_r <= 8'h00;
      app_b3_r <= 8'h00;
    end else begin
      app_new_r <= app_new;
      if (APP_ASSOC_WR) begin
        app_act_r <= !app_zero;
        app_code_r <= APP_ASSOC[15:0];
        app_b2_r <= APP_ASSOC[23:16];
        app_b3_r <= APP_ASSOC[31:24];
      end
    end
  end

  // --------------------------------------------------------------
  // Emergency state and message build
  // --------------------------------------------------------------
  cepo_emst_e em_st_r;
  logic pend_r;
  logic em_event;
  logic take;
  logic [15:0] msg_code;
  logic [7:0] msg_b2;
  logic [7:0] msg_b5;
  cepo_emcy_if emcy ();

  // Nothing is sent after reset unless an error is seen
  assign em_event = drv_new || app_new_r || part_clear ||
    all_clear;
  assign take = pend_r && !emcy.busy;

  // An event in the hand-over cycle re-arms, so none is lost
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pend_r <= 1'b0;
    end else if (em_event) begin
      pend_r <= 1'b1;
    end else if (take) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      em_st_r <= EM_FREE;
    end else begin
      unique case (em_st_r)
        EM_FREE: begin
          if (any_act) begin
            em_st_r <= EM_ERROR;
          end
        end
        EM_ERROR: begin
          if (!any_act) begin
            em_st_r <= EM_FREE;
          end
        end
      endcase
    end
  end

  always_comb begin
    if (DRV_TRIP) begin
      msg_code = last_code_r;
    end else if (app_act_r) begin
      msg_code = app_code_r;
    end else begin
      msg_code = CODE_CLEAR;
    end
    msg_b2 = err_reg_r;
    msg_b5 = 8'h00;
    if (app_act_r) begin
      msg_b2 = err_reg_r | app_b2_r;
      msg_b5 = app_b3_r;
    end
  end

  assign emcy.send = take;
  assign emcy.msg = {16'h0000, msg_b5, MOD_ERR_CODE,
    (DRV_TRIP ? DRV_TRIP_CODE : 8'h00), msg_b2, msg_code};

  cepo_emcy_tx u_tx (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .req(emcy),
    .tx_ready(EMCY_READY),
    .tx_valid(EMCY_VALID),
    .tx_data(EMCY_DATA)
  );

  // --------------------------------------------------------------
  // Object access and profile selection
  // --------------------------------------------------------------
  logic prof_en_r;
  logic [7:0] mode_r;
  logic tq_on;
  logic vl_on;
  logic ack_r;
  logic err_r;
  logic [31:0] rdata_r;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      prof_en_r <= PROF_EN_RST;
    end else if (PROFILE_ENABLE_WR) begin
      prof_en_r <= PROFILE_ENABLE_PARAM;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_r <= MODE_RST;
    end else if (OD_REQ && OD_WR && OD_INDEX == IDX_MODE_OP) begin
      mode_r <= OD_WDATA[7:0];
    end
  end

  assign tq_on = prof_en_r && mode_r == MODE_TQ;
  assign vl_on = prof_en_r && mode_r == MODE_VL;

  // Read-only objects refuse writes; mode object is write-only
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= OD_REQ;
      err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      if (OD_REQ && OD_WR) begin
        err_r <= OD_INDEX != IDX_MODE_OP;
      end else if (OD_REQ) begin
        unique case (OD_INDEX)
          IDX_ERR_REG: rdata_r <= {24'h00_0000, err_reg_r};
          IDX_LAST_CODE: rdata_r <= {16'h0000, last_code_r};
          IDX_SUP_MODES: rdata_r <= SUP_MODES_VAL;
          IDX_MODE_DISP: rdata_r <= {24'h00_0000, mode_r};
          default: err_r <= 1'b1;
        endcase
      end
    end
  end

  assign OD_ACK = ack_r;
  assign OD_ERR = err_r;
  assign OD_RDATA = rdata_r;

  // --------------------------------------------------------------
  // Process data mapping
  // --------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic [15:0] tq_tgt_r;
  logic [15:0] vl_tgt_r;
  logic [31:0] tpdo5_r;
  logic [31:0] tpdo6_r;
  logic signed [15:0] effort_rpm;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_r <= 16'h0000;
      tq_tgt_r <= 16'h0000;
      vl_tgt_r <= 16'h0000;
    end else if (RPDO_VALID) begin
      if (tq_on && RPDO_NUM == PDO_TQ) begin
        ctrl_r <= RPDO_DATA[15:0];
        tq_tgt_r <= RPDO_DATA[31:16];
      end else if (vl_on && RPDO_NUM == PDO_VL) begin
        ctrl_r <= RPDO_DATA[15:0];
        vl_tgt_r <= RPDO_DATA[31:16];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      tpdo5_r <= 32'h0000_0000;
      tpdo6_r <= 32'h0000_0000;
    end else begin
      tpdo5_r <= tq_on ? {TORQUE_ACTUAL, STATUSWORD} :
        32'h0000_0000;
      tpdo6_r <= vl_on ? {effort_rpm, STATUSWORD} :
        32'h0000_0000;
    end
  end

  assign CONTROLWORD = ctrl_r;
  assign TARGET_TORQUE = tq_tgt_r;
  assign VL_TARGET_VELOCITY = vl_tgt_r;
  assign TPDO5_DATA = tpdo5_r;
  assign TPDO6_DATA = tpdo6_r;

  // --------------------------------------------------------------
  // Unit conversion
  // --------------------------------------------------------------
  // Pole pairs are sampled every cycle, so a motor change is seen
  // at once; wide products avoid overflow, but the open-loop ramp truncates OL_RAMP_NUM / pole pairs first
  function automatic logic signed [15:0] sat16(
    input logic signed [47:0] v);
    if (v > 48'(S16_MAX)) begin
      sat16 = S16_MAX;
    end else if (v < 48'(S16_MIN)) begin
      sat16 = S16_MIN;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  logic signed [47:0] pp_s;
  logic signed [47:0] hz_w;
  logic signed [47:0] rpm_w;
  logic [47:0] ramp_w;
  logic [15:0] speed_ref_r;
  logic [31:0] ramp_r;
  logic ramp_sat;

  assign pp_s = signed'(48'(MOTOR_POLE_PAIRS));
  assign hz_w = 48'(signed'(vl_tgt_r)) * pp_s / SECS_PER_MIN;

  always_comb begin
    rpm_w = 48'(signed'(DRIVE_SPEED_FB));
    if (OPEN_LOOP && pp_s != 48'sd0) begin
      rpm_w = rpm_w * SECS_PER_MIN / pp_s;
    end
  end

  assign effort_rpm = (OPEN_LOOP && pp_s == 48'sd0) ? S16_MAX :
    sat16(rpm_w);

  always_comb begin
    ramp_sat = DELTA_SPEED == 32'h0000_0000;
    ramp_w = 48'h0000_0000_0000;
    if (OPEN_LOOP) begin
      ramp_sat = ramp_sat || MOTOR_POLE_PAIRS == 8'h00;
      if (!ramp_sat) begin
        ramp_w = 48'(DELTA_TIME) * (OL_RAMP_NUM / 48'(MOTOR_POLE_PAIRS))
          * OL_RAMP_SCALE / 48'(DELTA_SPEED);
      end
    end else if (!ramp_sat) begin
      ramp_w = 48'(DELTA_TIME) * CL_RAMP_SCALE /
        48'(DELTA_SPEED);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      speed_ref_r <= 16'h0000;
      ramp_r <= 32'h0000_0000;
    end else begin
      speed_ref_r <= OPEN_LOOP ? sat16(hz_w) : vl_tgt_r;
      ramp_r <= (ramp_sat || ramp_w > 48'(U32_MAX)) ? U32_MAX :
        ramp_w[31:0];
    end
  end

  assign DRIVE_SPEED_REF = speed_ref_r;
  assign DRIVE_RAMP = ramp_r;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  err_cur_a: assert property (
    DRV_OVERCURRENT |=> FAULT_CLASS_FLAGS[EB_CUR])
    else $error("Over-current not flagged");
  err_volt_a: assert property (
    DRV_UNDERVOLTAGE_TRIP |=> FAULT_CLASS_FLAGS[EB_VOLT])
    else $error("Undervoltage not flagged");
  err_temp_a: assert property (
    DRV_OVERTEMP |=> FAULT_CLASS_FLAGS[EB_TEMP])
    else $error("Over-temperature not flagged");
  err_gen_a: assert property (
    |FAULT_CLASS_FLAGS[7:1] |-> FAULT_CLASS_FLAGS[EB_GEN])
    else $error("Generic error bit missing");
  err_clear_a: assert property (
    !DRV_OVERCURRENT && !DRV_OVERTEMP |=>
      !FAULT_CLASS_FLAGS[EB_CUR] && !FAULT_CLASS_FLAGS[EB_TEMP])
    else $error("Error bit stuck after class cleared");
  app_emcy_a: assert property (
    app_new_r |=> pend_r || EMCY_VALID)
    else $error("Application code raised no emergency");
  emcy_or_a: assert property (
    take && app_act_r |-> emcy.msg[23:16] == (err_reg_r | app_b2_r)
      && emcy.msg[47:40] == app_b3_r)
    else $error("Application bytes not merged into message");
  all_clear_a: assert property (
    take && emcy.msg[15:0] == CODE_CLEAR |-> !DRV_TRIP && !app_act_r)
    else $error("All-clear sent while an error remains");
  prof_off_a: assert property (
    !prof_en_r |=> TPDO5_DATA == 32'h0000_0000 &&
      TPDO6_DATA == 32'h0000_0000)
    else $error("Profile data active while disabled");
  tq_map_a: assert property (
    RPDO_VALID && tq_on && RPDO_NUM == PDO_TQ |=>
      TARGET_TORQUE == $past(RPDO_DATA[31:16]))
    else $error("Torque target not mapped from word 1");
  code_cap_a: assert property (
    DRV_TRIP && !drv_prev_r |=> LAST_FAULT_CODE == $past(DRV_FAULT_CODE))
    else $error("Last fault code not captured");
  em_state_a: assert property (
    all_clear |-> em_st_r == EM_ERROR && !any_act)
    else $error("All-clear raised outside the error state");
endmodule
`default_nettype wire

// ---- verif/cepo_master_model.sv ----
// Network master model that takes emergency messages off the block
`timescale 1ns/1ps
`default_nettype none
module cepo_master_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic valid,
  input wire logic [63:0] data,
  output logic ready,
  output logic [7:0] n_msg,
  output logic [63:0] last
);
  logic [1:0] gap_r;
  // A busy master takes a message only one cycle in four
  assign ready = !slow || (gap_r == 2'h3);
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_r <= 2'h0;
      n_msg <= 8'h00;
      last <= 64'h0000_0000_0000_0000;
    end else begin
      gap_r <= gap_r + 2'h1;
      if (valid && ready) begin
        n_msg <= n_msg + 8'h01;
        last <= data;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_canopen_error_profile_objects.sv ----
// Self-checking bench of the error and drive profile objects
`timescale 1ns/1ps
`default_nettype none
module tb_canopen_error_profile_objects;
  import cepo_pkg::*;
  logic CORE_CLK = 1'b0;
  logic SYS_RST, DRV_TRIP, DRV_OVERCURRENT, DRV_UNDERVOLTAGE_TRIP;
  logic DRV_OVERTEMP, DRV_WARNING_PARAM, APP_ASSOC_WR, EMCY_READY;
  logic EMCY_VALID, OD_REQ, OD_WR, OD_ACK, OD_ERR, PROFILE_ENABLE_WR;
  logic PROFILE_ENABLE_PARAM, RPDO_VALID, OPEN_LOOP, slow, oerr;
  logic [3:0] RPDO_NUM;
  logic [7:0] DRV_TRIP_CODE, MOD_ERR_CODE, FAULT_CLASS_FLAGS, n_msg;
  logic [7:0] MOTOR_POLE_PAIRS;
  logic [15:0] DRV_FAULT_CODE, LAST_FAULT_CODE, OD_INDEX, STATUSWORD;
  logic [15:0] TORQUE_ACTUAL, DRIVE_SPEED_FB, CONTROLWORD, TARGET_TORQUE;
  logic [15:0] VL_TARGET_VELOCITY, DELTA_TIME, DRIVE_SPEED_REF;
  logic [31:0] APP_ASSOC, OD_WDATA, OD_RDATA, RPDO_DATA, TPDO5_DATA;
  logic [31:0] TPDO6_DATA, DELTA_SPEED, DRIVE_RAMP, rd;
  logic [63:0] EMCY_DATA, last;
  logic [7:0] fx [4];
  int errors, n_checks;

  cepo_objects dut (.*);
  cepo_master_model master (.clk(CORE_CLK), .rst(SYS_RST), .slow(slow),
    .valid(EMCY_VALID), .data(EMCY_DATA), .ready(EMCY_READY),
    .n_msg(n_msg), .last(last));

  always #50 CORE_CLK = ~CORE_CLK;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task endt(input string s);
    $display("test %s done", s);
  endtask
  // One object access; a spare cycle keeps strobes from meeting
  task od(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(negedge CORE_CLK);
    OD_WR = wr;
    OD_INDEX = idx;
    OD_WDATA = wd;
    OD_REQ = 1'b1;
    do begin
      @(negedge CORE_CLK);
      if (k == 0) OD_REQ = 1'b0;
      k++;
    end while (OD_ACK !== 1'b1 && k < 4);
    rd = OD_RDATA;
    oerr = OD_ERR;
    chk(OD_ACK, 1'b1);
  endtask
  task app(input logic [31:0] w);
    APP_ASSOC = w;
    APP_ASSOC_WR = 1'b1;
    @(negedge CORE_CLK);
    APP_ASSOC_WR = 1'b0;
  endtask
  task emcy(input logic [7:0] n);
    int k;
    k = 0;
    while (n_msg !== n && k < 40) begin
      @(negedge CORE_CLK);
      k++;
    end
    chk(n_msg, n);
  endtask
  task rpdo(input logic [3:0] num, input logic [31:0] d);
    @(negedge CORE_CLK);
    RPDO_NUM = num;
    RPDO_DATA = d;
    RPDO_VALID = 1'b1;
    @(negedge CORE_CLK);
    RPDO_VALID = 1'b0;
    @(negedge CORE_CLK);
  endtask
  task conv(input logic ol, input logic [7:0] pp, input logic [15:0] fb,
            input logic [31:0] ds, input logic [15:0] eref,
            input logic [15:0] eeff, input logic [31:0] eramp);
    OPEN_LOOP = ol;
    MOTOR_POLE_PAIRS = pp;
    DRIVE_SPEED_FB = fb;
    DELTA_SPEED = ds;
    repeat (3) @(negedge CORE_CLK);
    chk(DRIVE_SPEED_REF, eref);
    chk(TPDO6_DATA, {eeff, STATUSWORD});
    chk(DRIVE_RAMP, eramp);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {DRV_TRIP, DRV_OVERCURRENT, DRV_UNDERVOLTAGE_TRIP} = '0;
    {DRV_OVERTEMP, DRV_WARNING_PARAM, APP_ASSOC_WR, OD_REQ, OD_WR} = '0;
    {PROFILE_ENABLE_WR, PROFILE_ENABLE_PARAM, RPDO_VALID, OPEN_LOOP} = '0;
    {slow, RPDO_NUM, DRV_TRIP_CODE, MOD_ERR_CODE, MOTOR_POLE_PAIRS} = '0;
    {DRV_FAULT_CODE, OD_INDEX, STATUSWORD, TORQUE_ACTUAL} = '0;
    {DRIVE_SPEED_FB, APP_ASSOC, OD_WDATA, RPDO_DATA, DELTA_SPEED} = '0;
    DELTA_TIME = 16'h000A;
    SYS_RST = 1'b1;
    fx = '{8'h03, 8'h05, 8'h09, 8'h81};
    repeat (20) @(negedge CORE_CLK);
    SYS_RST = 1'b0;
    @(negedge CORE_CLK);
    chk({EMCY_VALID, FAULT_CLASS_FLAGS, LAST_FAULT_CODE}, 0);
    chk({CONTROLWORD, TARGET_TORQUE}, 0);
    od(1'b0, IDX_SUP_MODES, 32'h0);
    chk({oerr, rd}, {1'b0, SUP_MODES_VAL});
    od(1'b0, IDX_MODE_DISP, 32'h0);
    chk({oerr, rd}, 0);
    od(1'b1, IDX_ERR_REG, 32'h0000_00FF);
    chk(oerr, 1'b1);
    // The mode object is write-only, so a read is refused
    od(1'b0, IDX_MODE_OP, 32'h0000_0000);
    chk({oerr, rd}, {1'b1, 32'h0000_0000});
    endt("reset");
    for (int i = 0; i < 4; i++) begin
      {DRV_WARNING_PARAM, DRV_OVERTEMP, DRV_UNDERVOLTAGE_TRIP,
        DRV_OVERCURRENT} = 4'h1 << i;
      repeat (2) @(negedge CORE_CLK);
      chk(FAULT_CLASS_FLAGS, fx[i]);
    end
    od(1'b0, IDX_ERR_REG, 32'h0);
    chk(rd, 32'h0000_0081);
    DRV_WARNING_PARAM = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    chk(FAULT_CLASS_FLAGS, 8'h00);
    endt("flags");
    // Stalling master while the first trip is reported
    slow = 1'b1;
    DRV_OVERCURRENT = 1'b1;
    DRV_TRIP_CODE = 8'h14;
    DRV_FAULT_CODE = 16'h2300;
    MOD_ERR_CODE = 8'h42;
    DRV_TRIP = 1'b1;
    emcy(8'h01);
    chk(last, 64'h0000_0042_1403_2300);
    chk(LAST_FAULT_CODE, 16'h2300);
    od(1'b0, IDX_LAST_CODE, 32'h0);
    chk(rd, 32'h0000_2300);
    slow = 1'b0;
    app(32'h5A80_1234);
    emcy(8'h02);
    chk(last, 64'h0000_5A42_1483_2300);
    DRV_TRIP = 1'b0;
    DRV_OVERCURRENT = 1'b0;
    emcy(8'h03);
    chk(last[15:0], 16'h1234);
    app(32'h0);
    emcy(8'h04);
    chk(last[15:0], CODE_CLEAR);
    repeat (10) @(negedge CORE_CLK);
    chk(n_msg, 8'h04);
    // Trip outside the listed classes, then a new code while tripped
    DRV_FAULT_CODE = 16'h4200;
    DRV_TRIP = 1'b1;
    emcy(8'h05);
    chk(last, 64'h0000_0042_1401_4200);
    chk(FAULT_CLASS_FLAGS, 8'h01);
    DRV_FAULT_CODE = 16'h5000;
    emcy(8'h06);
    chk(last, 64'h0000_0042_1401_5000);
    chk(LAST_FAULT_CODE, 16'h5000);
    DRV_TRIP = 1'b0;
    emcy(8'h07);
    chk(last, 64'h0000_0042_0000_0000);
    repeat (10) @(negedge CORE_CLK);
    chk(n_msg, 8'h07);
    endt("emergency");
    od(1'b1, IDX_MODE_OP, {24'h0, MODE_TQ});
    chk(oerr, 1'b0);
    STATUSWORD = 16'h0237;
    TORQUE_ACTUAL = 16'h0100;
    rpdo(PDO_TQ, 32'h0BB8_000F);
    chk(CONTROLWORD, 16'h0000);
    PROFILE_ENABLE_PARAM = 1'b1;
    PROFILE_ENABLE_WR = 1'b1;
    @(negedge CORE_CLK);
    PROFILE_ENABLE_WR = 1'b0;
    rpdo(PDO_TQ, 32'h0BB8_000F);
    chk({TARGET_TORQUE, CONTROLWORD}, 32'h0BB8_000F);
    chk(TPDO5_DATA, 32'h0100_0237);
    rpdo(PDO_VL, 32'h05DC_0007);
    chk(VL_TARGET_VELOCITY, 16'h0000);
    od(1'b1, IDX_MODE_OP, {24'h0, MODE_VL});
    rpdo(PDO_VL, 32'h05DC_0007);
    chk({VL_TARGET_VELOCITY, CONTROLWORD}, 32'h05DC_0007);
    od(1'b0, IDX_MODE_DISP, 32'h0);
    chk(rd, {24'h0, MODE_VL});
    endt("profiles");
    conv(1'b0, 8'h02, 16'h05DC, 32'h0000_03E8, 16'h05DC, 16'h05DC,
      32'h0000_2710);
    conv(1'b1, 8'h02, 16'h0032, 32'h0000_0064, 16'h0032, 16'h05DC,
      32'h0000_0BB8);
    conv(1'b1, 8'h07, 16'h7530, 32'h0000_0064, 16'h00AF, 16'h7FFF,
      32'h0000_0352);
    conv(1'b1, 8'h00, 16'h0032, 32'h0000_0000, 16'h0000, 16'h7FFF,
      32'hFFFF_FFFF);
    endt("conversions");
    test_done;
  end

  initial begin
    repeat (5000) @(posedge CORE_CLK);
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
